// File: core/pkt_cfg_pkg.sv
// Function
// - Biphase bit enables Manchester coding both ways.
// - Body length fixes payload or caps receive length.
// - Keep 8-bit station identifier for address filtering.
// - Format bit picks fixed or variable length.
// - Lead-in code selects one to four preamble bytes.
// - Scramble bit whitens transmit, dewhitens receive data.
// - Check code bit enables CRC generate and verify.
// - Filter 00 accepts all, 01 station only.
// - Filter 10 accepts station or 0x00.
// - Filter 11 accepts station, 0x00 or 0xFF.
// - Check pass flag is read-only CRC result.
// - Clear FIFO on CRC failure unless discard disabled.
// - Standby direction bit picks host FIFO write/read.
package pkt_cfg_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register locations and reset values.
  localparam logic [7:0] LEN_CTRL_ADDR  = 8'h1c;
  localparam logic [7:0] STATION_ADDR   = 8'h1d;
  localparam logic [7:0] FORMAT_ADDR    = 8'h1e;
  localparam logic [7:0] FIFO_CTRL_ADDR = 8'h1f;
  localparam logic [7:0] LEN_CTRL_RST   = 8'h00;
  localparam logic [7:0] STATION_RST    = 8'h00;
  localparam logic [7:0] FORMAT_RST     = 8'h48;
  localparam logic [7:0] FIFO_CTRL_RST  = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int MANCH_BIT       = 7;
  localparam int LEN_HI          = 6;
  localparam int LEN_FMT_BIT     = 7;
  localparam int PRE_HI          = 6;
  localparam int PRE_LO          = 5;
  localparam int WHITE_BIT       = 4;
  localparam int CRC_EN_BIT      = 3;
  localparam int FILT_HI         = 2;
  localparam int FILT_LO         = 1;
  localparam int AUTOCLR_OFF_BIT = 7;
  localparam int STBY_DIR_BIT    = 6;

  //////////////////////////////////////////////////////////////////////////////
  // Codes and seeds.
  localparam logic [1:0]  FILT_OFF      = 2'h0;
  localparam logic [1:0]  FILT_NODE     = 2'h1;
  localparam logic [1:0]  FILT_NODE_00  = 2'h2;
  localparam logic [7:0]  BCAST_LOW     = 8'h00;
  localparam logic [7:0]  BCAST_HIGH    = 8'hff;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'haa;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_SEED      = 16'h1d0f;
  localparam logic [8:0]  PN9_SEED      = 9'h1ff;

  typedef enum logic [4:0] {
    TX_IDLE   = 5'h01,
    TX_PRE    = 5'h02,
    TX_BODY   = 5'h04,
    TX_CRC_HI = 5'h08,
    TX_CRC_LO = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'h01,
    RX_LEN    = 5'h02,
    RX_PAY    = 5'h04,
    RX_CRC_HI = 5'h08,
    RX_CRC_LO = 5'h10
  } rx_state_t;

  // Address acceptance for the four filter modes.
  function automatic logic addr_ok(input logic [1:0] mode, input logic [7:0] id,
                                   input logic [7:0] a);
    case (mode)
      FILT_OFF:     addr_ok = 1'b1;
      FILT_NODE:    addr_ok = (a == id);
      FILT_NODE_00: addr_ok = (a == id) || (a == BCAST_LOW);
      default:      addr_ok = (a == id) || (a == BCAST_LOW) || (a == BCAST_HIGH);
    endcase
  endfunction

  // Each data bit becomes a chip pair, one as 10 and zero as 01.
  function automatic logic [15:0] manch_enc(input logic [7:0] d);
    manch_enc = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      manch_enc[2*i+1] = d[i];
      manch_enc[2*i]   = ~d[i];
    end
  endfunction

  // The first chip of each pair carries the data bit.
  function automatic logic [7:0] manch_dec(input logic [15:0] c);
    manch_dec = 8'h00;
    for (int i = 0; i < 8; i++) begin
      manch_dec[i] = c[2*i+1];
    end
  endfunction

endpackage

// File: core/pkt_codec_if.sv
`timescale 1ns/100ps
// Byte-wide whitening and CRC service between the engine and a codec.
interface pkt_codec_if;
  logic        init;
  logic        step;
  logic        crc_upd;
  logic        is_rx;
  logic        whiten_en;
  logic [7:0]  din;
  logic [7:0]  dout;
  logic [15:0] crc;

  modport engine (output init, step, crc_upd, is_rx, whiten_en, din, input dout, crc);
  modport codec  (input init, step, crc_upd, is_rx, whiten_en, din, output dout, crc);
endinterface

// File: core/pkt_codec.sv
`timescale 1ns/100ps
module pkt_codec
  import pkt_cfg_pkg::*;
(
  // Clock and reset
  input wire logic    core_clk,
  input wire logic    sys_rst,
  // Engine side
  pkt_codec_if.codec  cif
);

  typedef struct packed {
    logic [8:0]  lfsr;
    logic [15:0] crc;
  } codec_t;

  codec_t st;
  codec_t next_st;
  logic [7:0] crc_src;

  // Advance the PN9 sequence by one byte.
  function automatic logic [8:0] pn9_step8(input logic [8:0] l);
    pn9_step8 = l;
    for (int i = 0; i < 8; i++) begin
      pn9_step8 = {pn9_step8[0] ^ pn9_step8[5], pn9_step8[8:1]};
    end
  endfunction

  // Fold one byte into the CRC, most significant bit first.
  function automatic logic [15:0] crc_step8(input logic [15:0] c, input logic [7:0] d);
    crc_step8 = c;
    for (int i = 7; i >= 0; i--) begin
      crc_step8 = {crc_step8[14:0], 1'b0} ^ ((crc_step8[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
  endfunction

  // Whitening is bypassed when disabled; CRC always covers plain data.
  assign cif.dout = cif.din ^ (cif.whiten_en ? st.lfsr[7:0] : 8'h00);
  assign crc_src  = cif.is_rx ? cif.dout : cif.din;
  assign cif.crc  = st.crc;

  // Next state of the sequence and the check word.
  always_comb begin
    next_st = st;
    if (cif.init) begin
      next_st.lfsr = PN9_SEED;
      next_st.crc  = CRC_SEED;
    end else if (cif.step) begin
      next_st.lfsr = pn9_step8(st.lfsr);
      if (cif.crc_upd) begin
        next_st.crc = crc_step8(st.crc, crc_src);
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{lfsr: PN9_SEED, crc: CRC_SEED};
    end else begin
      st <= next_st;
    end
  end

  AST_WHITE_BYPASS: assert property (@(posedge core_clk) disable iff (sys_rst)
    cif.step && !cif.whiten_en |-> cif.dout == cif.din)
    else $error("Data altered while whitening is off.");

  AST_CRC_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cif.init && !cif.crc_upd |=> $stable(cif.crc))
    else $error("CRC changed without an update.");

endmodule

// File: core/pkt_engine.sv
`timescale 1ns/100ps
module pkt_engine
  import pkt_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Configuration port
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  // Operating mode and FIFO control
  input  wire logic       stby_mode,
  output logic            fifo_host_wr_en,
  output logic            fifo_host_rd_en,
  output logic            fifo_clear,
  // Transmit path
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_in_data,
  input  wire logic       tx_in_valid,
  output logic            tx_in_ready,
  output logic      [7:0] tx_out_data,
  output logic            tx_out_valid,
  input  wire logic       tx_out_ready,
  output logic            tx_done,
  // Receive path
  input  wire logic       rx_start,
  input  wire logic [7:0] rx_in_data,
  input  wire logic       rx_in_valid,
  output logic      [7:0] rx_out_data,
  output logic            rx_out_valid,
  output logic            rx_done,
  output logic            rx_drop,
  output logic            crc_ok
);

  typedef struct packed {
    logic [7:0] len_ctrl;
    logic [7:0] station;
    logic [7:1] fmt_ctrl;
    logic [7:0] fifo_ctrl;
    logic [7:0] rdata;
    tx_state_t  tx_st;
    logic [1:0] pre_cnt;
    logic [7:0] tx_cnt;
    logic       tx_first;
    logic       tx_half;
    logic [7:0] tx_lo;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       tx_done;
    rx_state_t  rx_st;
    logic [7:0] rx_cnt;
    logic       rx_first;
    logic       rx_half;
    logic [7:0] rx_hi;
    logic [7:0] rx_crc_hi;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_done;
    logic       rx_drop;
    logic       crc_ok;
    logic       fifo_clear;
  } state_t;

  state_t st;
  state_t next_st;

  pkt_codec_if tx_cif ();
  pkt_codec_if rx_cif ();

  pkt_codec u_tx_codec (.core_clk(core_clk), .sys_rst(sys_rst), .cif(tx_cif.codec));
  pkt_codec u_rx_codec (.core_clk(core_clk), .sys_rst(sys_rst), .cif(rx_cif.codec));

  //////////////////////////////////////////////////////////////////////////////
  // Configuration fields.
  logic       manch_on;
  logic       var_fmt;
  logic       crc_on;
  logic [1:0] filt_mode;
  logic [7:0] max_len;
  assign manch_on  = st.len_ctrl[MANCH_BIT];
  assign max_len   = {1'b0, st.len_ctrl[LEN_HI:0]};
  assign var_fmt   = st.fmt_ctrl[LEN_FMT_BIT];
  assign crc_on    = st.fmt_ctrl[CRC_EN_BIT];
  assign filt_mode = st.fmt_ctrl[FILT_HI:FILT_LO];

  //////////////////////////////////////////////////////////////////////////////
  // Transmit handshakes and codec feed.
  logic slot_free;
  logic tx_take;
  logic crc_emit;
  assign slot_free   = !st.tx_valid || tx_out_ready;
  assign tx_in_ready = slot_free && !st.tx_half && (st.tx_st == TX_BODY);
  assign tx_take     = tx_in_ready && tx_in_valid;
  assign crc_emit    = slot_free && !st.tx_half
                       && (st.tx_st == TX_CRC_HI || st.tx_st == TX_CRC_LO);

  assign tx_cif.init      = tx_start && (st.tx_st == TX_IDLE);
  assign tx_cif.step      = tx_take || crc_emit;
  assign tx_cif.crc_upd   = tx_take;
  assign tx_cif.is_rx     = 1'b0;
  assign tx_cif.whiten_en = st.fmt_ctrl[WHITE_BIT];
  assign tx_cif.din       = tx_take ? tx_in_data :
                            (st.tx_st == TX_CRC_HI) ? tx_cif.crc[15:8] : tx_cif.crc[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Receive byte assembly and codec feed.
  logic       rx_byte_evt;
  logic       len_evt;
  logic       addr_evt;
  logic       chk_evt;
  logic [7:0] plain;
  logic       crc_match;
  assign rx_byte_evt = rx_in_valid && (st.rx_st != RX_IDLE) && (!manch_on || st.rx_half);
  assign len_evt     = rx_byte_evt && (st.rx_st == RX_LEN);
  assign addr_evt    = rx_byte_evt && (st.rx_st == RX_PAY) && st.rx_first
                       && (filt_mode != FILT_OFF);
  assign chk_evt     = rx_byte_evt && (st.rx_st == RX_CRC_LO);
  assign plain       = rx_cif.dout;
  assign crc_match   = ({st.rx_crc_hi, plain} == rx_cif.crc);

  assign rx_cif.init      = rx_start;
  assign rx_cif.step      = rx_byte_evt;
  assign rx_cif.crc_upd   = rx_byte_evt && (st.rx_st == RX_LEN || st.rx_st == RX_PAY);
  assign rx_cif.is_rx     = 1'b1;
  assign rx_cif.whiten_en = st.fmt_ctrl[WHITE_BIT];
  assign rx_cif.din       = manch_on ? manch_dec({st.rx_hi, rx_in_data}) : rx_in_data;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, transmitter and receiver.
  always_comb begin
    logic        body_end;
    logic [15:0] enc;
    body_end = 1'b0;
    enc      = manch_enc(tx_cif.dout);
    next_st            = st;
    next_st.tx_done    = 1'b0;
    next_st.rx_done    = 1'b0;
    next_st.rx_drop    = 1'b0;
    next_st.rx_valid   = 1'b0;
    next_st.fifo_clear = 1'b0;
    if (slot_free) begin
      next_st.tx_valid = 1'b0;
    end

    // Register writes; the pass flag is not writable.
    if (cfg_wr) begin
      case (cfg_addr)
        LEN_CTRL_ADDR:  next_st.len_ctrl = cfg_wdata;
        STATION_ADDR:   next_st.station = cfg_wdata;
        FORMAT_ADDR:    next_st.fmt_ctrl = cfg_wdata[7:1];
        FIFO_CTRL_ADDR: next_st.fifo_ctrl = cfg_wdata;
        default: ;
      endcase
    end
    if (cfg_rd) begin
      case (cfg_addr)
        LEN_CTRL_ADDR:  next_st.rdata = st.len_ctrl;
        STATION_ADDR:   next_st.rdata = st.station;
        FORMAT_ADDR:    next_st.rdata = {st.fmt_ctrl, st.crc_ok};
        FIFO_CTRL_ADDR: next_st.rdata = st.fifo_ctrl;
        default:        next_st.rdata = 8'h00;
      endcase
    end

    // Transmit sequence: preamble, body, optional check word.
    case (st.tx_st)
      TX_IDLE: begin
        if (tx_start) begin
          next_st.tx_st    = TX_PRE;
          next_st.pre_cnt  = st.fmt_ctrl[PRE_HI:PRE_LO];
          next_st.tx_first = var_fmt;
          next_st.tx_cnt   = max_len;
        end
      end
      TX_PRE: begin
        if (slot_free && !st.tx_half) begin
          next_st.tx_data  = PREAMBLE_BYTE;
          next_st.tx_valid = 1'b1;
          next_st.pre_cnt  = st.pre_cnt - 2'h1;
          if (st.pre_cnt == 2'h0) begin
            next_st.tx_st = TX_BODY;
          end
        end
      end
      TX_BODY: begin
        if (tx_take) begin
          if (st.tx_first) begin
            next_st.tx_first = 1'b0;
            next_st.tx_cnt   = tx_in_data;
            body_end         = (tx_in_data == 8'h00);
          end else begin
            next_st.tx_cnt = st.tx_cnt - 8'h01;
            body_end       = (st.tx_cnt == 8'h01);
          end
          if (body_end) begin
            next_st.tx_st   = crc_on ? TX_CRC_HI : TX_IDLE;
            next_st.tx_done = !crc_on;
          end
        end
      end
      TX_CRC_HI: begin
        if (crc_emit) begin
          next_st.tx_st = TX_CRC_LO;
        end
      end
      TX_CRC_LO: begin
        if (crc_emit) begin
          next_st.tx_st   = TX_IDLE;
          next_st.tx_done = 1'b1;
        end
      end
      default: next_st.tx_st = TX_IDLE;
    endcase

    // Coded bytes go out whole, or as two chip bytes when biphase coding is on.
    if (tx_take || crc_emit) begin
      next_st.tx_valid = 1'b1;
      if (manch_on) begin
        next_st.tx_data = enc[15:8];
        next_st.tx_lo   = enc[7:0];
        next_st.tx_half = 1'b1;
      end else begin
        next_st.tx_data = tx_cif.dout;
      end
    end else if (slot_free && st.tx_half) begin
      next_st.tx_data  = st.tx_lo;
      next_st.tx_valid = 1'b1;
      next_st.tx_half  = 1'b0;
    end

    // Receive chip pairing.
    if (rx_in_valid && st.rx_st != RX_IDLE && manch_on) begin
      next_st.rx_half = !st.rx_half;
      if (!st.rx_half) begin
        next_st.rx_hi = rx_in_data;
      end
    end

    // Receive sequence: length, filtered payload, check word.
    case (st.rx_st)
      RX_IDLE: ;
      RX_LEN: begin
        if (len_evt) begin
          if (plain == 8'h00 || plain > max_len) begin
            next_st.rx_st   = RX_IDLE;
            next_st.rx_drop = 1'b1;
          end else begin
            next_st.rx_cnt = plain;
            next_st.rx_st  = RX_PAY;
          end
        end
      end
      RX_PAY: begin
        if (rx_byte_evt) begin
          next_st.rx_first = 1'b0;
          if (addr_evt && !addr_ok(filt_mode, st.station, plain)) begin
            next_st.rx_st   = RX_IDLE;
            next_st.rx_drop = 1'b1;
          end else begin
            next_st.rx_data  = plain;
            next_st.rx_valid = 1'b1;
            next_st.rx_cnt   = st.rx_cnt - 8'h01;
            if (st.rx_cnt == 8'h01) begin
              next_st.rx_st   = crc_on ? RX_CRC_HI : RX_IDLE;
              next_st.rx_done = !crc_on;
            end
          end
        end
      end
      RX_CRC_HI: begin
        if (rx_byte_evt) begin
          next_st.rx_crc_hi = plain;
          next_st.rx_st     = RX_CRC_LO;
        end
      end
      RX_CRC_LO: begin
        if (chk_evt) begin
          next_st.crc_ok     = crc_match;
          next_st.fifo_clear = !crc_match && !st.fifo_ctrl[AUTOCLR_OFF_BIT];
          next_st.rx_done    = 1'b1;
          next_st.rx_st      = RX_IDLE;
        end
      end
      default: next_st.rx_st = RX_IDLE;
    endcase

    // A new sync restarts the receiver from any state.
    if (rx_start) begin
      next_st.rx_st    = var_fmt ? RX_LEN : RX_PAY;
      next_st.rx_cnt   = max_len;
      next_st.rx_first = 1'b1;
      next_st.rx_half  = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{len_ctrl: LEN_CTRL_RST, station: STATION_RST, fmt_ctrl: FORMAT_RST[7:1],
              fifo_ctrl: FIFO_CTRL_RST, tx_st: TX_IDLE, rx_st: RX_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs.
  assign cfg_rdata       = st.rdata;
  assign tx_out_data     = st.tx_data;
  assign tx_out_valid    = st.tx_valid;
  assign tx_done         = st.tx_done;
  assign rx_out_data     = st.rx_data;
  assign rx_out_valid    = st.rx_valid;
  assign rx_done         = st.rx_done;
  assign rx_drop         = st.rx_drop;
  assign crc_ok          = st.crc_ok;
  assign fifo_clear      = st.fifo_clear;
  assign fifo_host_wr_en = stby_mode && !st.fifo_ctrl[STBY_DIR_BIT];
  assign fifo_host_rd_en = stby_mode && st.fifo_ctrl[STBY_DIR_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_FLAG_STABLE: assert property (!$stable(crc_ok) |-> $past(chk_evt))
    else $error("Pass flag moved outside a check.");
  AST_FLAG_RO: assert property (cfg_wr && cfg_addr == FORMAT_ADDR && !chk_evt
    |=> $stable(crc_ok)) else $error("Write changed the pass flag.");
  AST_AUTOCLR: assert property (chk_evt && !crc_match
    |=> fifo_clear == !$past(st.fifo_ctrl[AUTOCLR_OFF_BIT])) else $error("Bad FIFO clear.");
  AST_FILTER: assert property (addr_evt && !addr_ok(filt_mode, st.station, plain)
    |=> rx_drop && !rx_out_valid) else $error("Filtered address not rejected.");
  AST_MAXLEN: assert property (len_evt && plain > max_len |=> rx_drop)
    else $error("Overlong packet accepted.");
  AST_PRE_LEN: assert property (tx_start && st.tx_st == TX_IDLE
    |=> st.pre_cnt == $past(st.fmt_ctrl[PRE_HI:PRE_LO])) else $error("Wrong preamble length.");
  AST_MANCH: assert property ($rose(st.tx_half) |-> $past(manch_on))
    else $error("Chip split without biphase coding.");
  AST_CRC_OFF: assert property ($rose(st.tx_st == TX_CRC_HI) |-> $past(crc_on))
    else $error("Check word sent while disabled.");
  AST_FIX_LEN: assert property (rx_start && !var_fmt
    |=> st.rx_st == RX_PAY && st.rx_cnt == $past(max_len)) else $error("Bad fixed length.");
  AST_FIFO_DIR: assert property (stby_mode |-> fifo_host_rd_en != fifo_host_wr_en)
    else $error("FIFO direction not exclusive.");

  COV_PASS: cover property (chk_evt && crc_match);
  COV_CLEAR: cover property (fifo_clear);
  COV_TX_MANCH: cover property (tx_done && manch_on);

endmodule

// File: tb/peer_model.sv
`timescale 1ns/100ps
// Far-end radio peer: sinks transmit bytes and sends received frames.
module peer_model (
  // Clock
  input  wire logic       core_clk,
  // Transmit stream from the engine
  input  wire logic [7:0] tx_out_data,
  input  wire logic       tx_out_valid,
  output logic            tx_out_ready,
  // Receive stream into the engine
  output logic            rx_start,
  output logic      [7:0] rx_in_data,
  output logic            rx_in_valid
);
  logic [7:0] got[$];
  logic       slow;
  int         cyc;

  //////////////////////////////////////////////////////////////////////////////
  // Quiet lines at time zero.
  initial begin
    slow         = 1'b0;
    cyc          = 0;
    tx_out_ready = 1'b1;
    rx_start     = 1'b0;
    rx_in_valid  = 1'b0;
    rx_in_data   = 8'h00;
  end

  // Collect accepted bytes; a slow peer stalls every other cycle.
  always @(posedge core_clk) begin
    if (tx_out_valid && tx_out_ready) begin
      got.push_back(tx_out_data);
    end
    cyc++;
    #1 tx_out_ready = !slow || cyc[0];
  end

  // One frame after a sync pulse, one byte a cycle; the line then shows junk.
  task automatic send(input logic [7:0] b[$]);
    @(posedge core_clk) #1 rx_start = 1'b1;
    @(posedge core_clk) #1 rx_start = 1'b0;
    foreach (b[i]) begin
      rx_in_data  = b[i];
      rx_in_valid = 1'b1;
      @(posedge core_clk) #1;
    end
    rx_in_valid = 1'b0;
    rx_in_data  = ~rx_in_data;
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pkt_cfg_pkg::*;
  logic       core_clk, sys_rst, cfg_wr, cfg_rd, stby_mode, tx_start;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, tx_in_data, tx_out_data, rx_in_data, rx_out_data;
  logic       fifo_host_wr_en, fifo_host_rd_en, fifo_clear, tx_in_valid, tx_in_ready;
  logic       tx_out_valid, tx_out_ready, tx_done, rx_start, rx_in_valid, rx_out_valid;
  logic       rx_done, rx_drop, crc_ok, seen_done, seen_drop, seen_clr;
  logic [7:0] txq[$], rx_last;
  int         txi, cycles, err_count, check_count;

  pkt_engine dut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .stby_mode(stby_mode),
    .fifo_host_wr_en(fifo_host_wr_en), .fifo_host_rd_en(fifo_host_rd_en),
    .fifo_clear(fifo_clear), .tx_start(tx_start), .tx_in_data(tx_in_data),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_out_data(tx_out_data),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_done(tx_done),
    .rx_start(rx_start), .rx_in_data(rx_in_data), .rx_in_valid(rx_in_valid),
    .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid), .rx_done(rx_done),
    .rx_drop(rx_drop), .crc_ok(crc_ok));

  peer_model peer (.core_clk(core_clk), .tx_out_data(tx_out_data), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .rx_start(rx_start), .rx_in_data(rx_in_data),
    .rx_in_valid(rx_in_valid));

  //////////////////////////////////////////////////////////////////////////////
  // Clock, payload feeder, receive event monitor and hang guard.
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (tx_in_valid && tx_in_ready) txi++;
    #1 tx_in_valid = (txi < txq.size());
    tx_in_data = tx_in_valid ? txq[txi] : 8'h00;
  end

  always @(posedge core_clk) begin
    if (rx_done === 1'b1) seen_done = 1'b1;
    if (rx_drop === 1'b1) seen_drop = 1'b1;
    if (fifo_clear === 1'b1) seen_clr = 1'b1;
    if (rx_out_valid === 1'b1) rx_last = rx_out_data;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge core_clk) #1 cfg_addr = a;
    cfg_wdata = d;
    cfg_wr    = 1'b1;
    @(posedge core_clk) #1 cfg_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) #1 cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge core_clk) #1 cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask

  // CCITT check over plain bytes, most significant bit first.
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    logic        fb;
    c = CRC_SEED;
    foreach (b[i]) begin
      for (int j = 7; j >= 0; j--) begin
        fb = c[15] ^ b[i][j];
        c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic tx_case(input logic [7:0] fmt, len, input logic [7:0] p[$], e[$]);
    reg_wr(LEN_CTRL_ADDR, len);
    reg_wr(FORMAT_ADDR, fmt);
    @(negedge core_clk);
    txq = p;
    txi = 0;
    peer.got.delete();
    peer.slow = ~peer.slow;
    @(posedge core_clk) #1 tx_start = 1'b1;
    @(posedge core_clk) #1 tx_start = 1'b0;
    for (int k = 0; k < 300 && tx_done !== 1'b1; k++) @(posedge core_clk) #1;
    repeat (20) @(posedge core_clk) #1;
    check("tx count", 8'(e.size()), 8'(peer.got.size()));
    foreach (e[i]) check("tx byte", e[i], peer.got[i]);
  endtask

  task automatic rx_case(input logic [7:0] f[$], input logic ok, clr);
    seen_done = 1'b0;
    seen_drop = 1'b0;
    seen_clr  = 1'b0;
    peer.send(f);
    repeat (4) @(posedge core_clk) #1;
    check("rx done", {7'h00, ok}, {7'h00, seen_done});
    check("rx drop", {7'h00, !ok}, {7'h00, seen_drop});
    check("fifo clear", {7'h00, clr}, {7'h00, seen_clr});
  endtask

  task automatic reg_case();
    logic [7:0] d;
    reg_rd(LEN_CTRL_ADDR, d);
    check("len ctrl", 8'h00, d);
    reg_rd(STATION_ADDR, d);
    check("station", 8'h00, d);
    reg_rd(FORMAT_ADDR, d);
    check("format", 8'h48, d);
    reg_rd(FIFO_CTRL_ADDR, d);
    check("fifo ctrl", 8'h00, d);
    reg_rd(8'h20, d);
    check("unmapped", 8'h00, d);
    reg_wr(FORMAT_ADDR, 8'hff);
    reg_rd(FORMAT_ADDR, d);
    check("format", 8'hfe, d);
    reg_wr(STATION_ADDR, 8'ha5);
    reg_rd(STATION_ADDR, d);
    check("station", 8'ha5, d);
    reg_wr(FIFO_CTRL_ADDR, 8'h40);
    @(posedge core_clk) #1 stby_mode = 1'b1;
    @(posedge core_clk) #1;
    check("host rd", 8'h01, {7'h00, fifo_host_rd_en});
    check("host wr", 8'h00, {7'h00, fifo_host_wr_en});
    reg_wr(FIFO_CTRL_ADDR, 8'h00);
    check("host wr", 8'h01, {7'h00, fifo_host_wr_en});
    stby_mode = 1'b0;
    @(posedge core_clk) #1;
    check("host wr", 8'h00, {7'h00, fifo_host_wr_en});
  endtask

  task automatic filter_case();
    logic [7:0] a[4];
    logic       acc;
    a = '{8'h5a, 8'h00, 8'hff, 8'h33};
    reg_wr(LEN_CTRL_ADDR, 8'h05);
    reg_wr(STATION_ADDR, 8'h5a);
    for (int m = 0; m < 4; m++) begin
      reg_wr(FORMAT_ADDR, 8'h80 | 8'(m << 1));
      for (int i = 0; i < 4; i++) begin
        acc = (m == 0) || (a[i] == 8'h5a) || (m >= 2 && a[i] == 8'h00)
              || (m == 3 && a[i] == 8'hff);
        rx_case('{8'h02, a[i], 8'h11}, acc, 1'b0);
      end
    end
    rx_case('{8'h06, 8'h5a}, 1'b0, 1'b0);
  endtask

  task automatic crc_case();
    logic [7:0]  p[$];
    logic [15:0] c;
    logic [7:0]  d;
    p = '{8'h3c, 8'h81};
    c = crc16(p);
    reg_wr(LEN_CTRL_ADDR, 8'h02);
    reg_wr(FORMAT_ADDR, 8'h08);
    rx_case('{8'h3c, 8'h81, c[15:8], c[7:0]}, 1'b1, 1'b0);
    reg_rd(FORMAT_ADDR, d);
    check("format", 8'h09, d);
    reg_wr(FORMAT_ADDR, 8'h00);
    rx_case(p, 1'b1, 1'b0);
    check("crc flag", 8'h01, {7'h00, crc_ok});
    reg_wr(FORMAT_ADDR, 8'h08);
    rx_case('{8'h3c, 8'h81, c[15:8], ~c[7:0]}, 1'b1, 1'b1);
    check("crc flag", 8'h00, {7'h00, crc_ok});
    reg_wr(FIFO_CTRL_ADDR, 8'h80);
    rx_case('{8'h3c, 8'h81, ~c[15:8], c[7:0]}, 1'b1, 1'b0);
    reg_wr(LEN_CTRL_ADDR, 8'h81);
    reg_wr(FORMAT_ADDR, 8'h10);
    rx_case('{8'haa, 8'h55}, 1'b1, 1'b0);
    check("rx data", 8'h0f, rx_last);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [7:0]  p[$];
    logic [15:0] c;
    core_clk    = 1'b0;
    sys_rst     = 1'b1;
    cfg_wr      = 1'b0;
    cfg_rd      = 1'b0;
    cfg_addr    = 8'h00;
    cfg_wdata   = 8'h00;
    stby_mode   = 1'b0;
    tx_start    = 1'b0;
    tx_in_valid = 1'b0;
    tx_in_data  = 8'h00;
    repeat (6) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    reg_case();
    p = '{8'h3c, 8'h81};
    c = crc16(p);
    tx_case(8'h00, 8'h02, p, '{8'haa, 8'h3c, 8'h81});
    tx_case(8'h68, 8'h02, p,
            '{8'haa, 8'haa, 8'haa, 8'haa, 8'h3c, 8'h81, c[15:8], c[7:0]});
    tx_case(8'h00, 8'h81, '{8'h0f}, '{8'haa, 8'h55, 8'haa});
    tx_case(8'h10, 8'h01, '{8'h00}, '{8'haa, 8'hff});
    tx_case(8'h80, 8'h00, '{8'h01, 8'h3c}, '{8'haa, 8'h01, 8'h3c});
    filter_case();
    crc_case();
    complete_run();
  end
endmodule
